// file: core/static_line_port.sv
// Static digital line port: 32 data lines plus a four-bit auxiliary control-line port.
// Assumes an APB master on clock, and an external pad ring that resolves pins and pulls.
//
// Behaviour
// - Every line read or write is triggered only by a software register access.
// - Each of the 32 data lines has its own direction setting.
// - Open-drain lines drive low only and release the pin for high.
// - Driven outputs drive both levels whatever the data pull select says.
// - Data pull select sets the level undriven data lines settle to.
// - Reading an open-drain line returns the real pin level.
// - Two independent timing groups each own four control lines.
// - A group in handshake or pattern mode withholds its control lines.
// - Idle groups give eight control lines: four inputs, four driven outputs.
// - The auxiliary port is four bits wide.
// - Aux writes touch only outputs; aux reads return only inputs.
// - Aux inputs: stop triggers 1,2, asks 1,2; outputs: clocks 1,2, replies 1,2.
// - Whole aux port only when both groups free, else line by line.
// - Masked accesses touch only selected lines, never busy-group lines.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module static_line_port #(
	parameter int DataWidth = 32,
	parameter int AuxWidth = 4
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [DataWidth-1:0] dataLineIn,
	output logic [DataWidth-1:0] dataLineOut,
	output logic [DataWidth-1:0] dataLineOen,
	input wire logic dataPullSelect,
	input wire logic controlPullSelect,
	input wire logic [1:0] stopTriggerLine,
	input wire logic [1:0] askLine,
	output logic [1:0] peripheralClockLine,
	output logic [1:0] replyLine,
	output logic [1:0] controlLineOen
);
	logic [DataWidth-1:0] dataOut_reg;
	logic [DataWidth-1:0] outEnable_reg;
	logic [DataWidth-1:0] openDrain_reg;
	logic [DataWidth-1:0] dataMask_reg;
	logic [AuxWidth-1:0] auxOut_reg;
	logic [AuxWidth-1:0] auxLineMask_reg;
	logic [static_line_pkg::GroupModeWidth-1:0] groupMode_reg;
	logic [DataWidth-1:0] dataSync;
	logic [AuxWidth-1:0] auxSync;
	logic [DataWidth-1:0] pinNext;
	logic [DataWidth-1:0] oenNext;
	logic [AuxWidth-1:0] auxFree;
	logic [AuxWidth-1:0] auxOutNext;
	logic [AuxWidth-1:0] auxWriteSel;
	logic [AuxWidth-1:0] auxReadSel;
	logic [31:0] prdata_next;
	logic [31:0] wrMerged;
	logic group1Busy;
	logic group2Busy;
	logic auxPortFree;
	logic setupPhase;
	logic accessDone_reg;
	logic wrStrobe;
	logic addrValid;
	logic [1:0] pullSync;
	logic [1:0] pullLevel_reg;

	// Pin inputs are asynchronous; data lines and aux inputs pass three stages
	pin_sync #(
		.Width(DataWidth)
	) u_data_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn(dataLineIn),
		.pinOut(dataSync)
	);

	pin_sync #(
		.Width(AuxWidth)
	) u_aux_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn({askLine, stopTriggerLine}),
		.pinOut(auxSync)
	);

	// Pull selects are pin levels too; bit 0 data pull, bit 1 control pull
	pin_sync #(
		.Width(2)
	) u_pull_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn({controlPullSelect, dataPullSelect}),
		.pinOut(pullSync)
	);

	// Group busy whenever its mode is not idle
	always_comb
	begin
		group1Busy = groupMode_reg[static_line_pkg::Group1Lsb +: 2] != static_line_pkg::ModeIdle;
		group2Busy = groupMode_reg[static_line_pkg::Group2Lsb +: 2] != static_line_pkg::ModeIdle;
		auxPortFree = !group1Busy && !group2Busy;
		// Aux bit 0 and 2 belong to group 1, bits 1 and 3 to group 2
		auxFree = {!group2Busy, !group1Busy, !group2Busy, !group1Busy};
	end

	// APB decode; zero-wait answer one cycle after setup
	always_comb
	begin
		setupPhase = psel && !penable;
		wrStrobe = psel && penable && pwrite && !accessDone_reg;
		unique case (paddr)
			static_line_pkg::OffDataOut, static_line_pkg::OffDataIn,
			static_line_pkg::OffOutEnable, static_line_pkg::OffOpenDrain,
			static_line_pkg::OffAuxPort, static_line_pkg::OffAuxLineMask,
			static_line_pkg::OffGroupMode, static_line_pkg::OffStatus,
			static_line_pkg::OffDataMask:
				addrValid = 1'b1;
			default:
				addrValid = 1'b0;
		endcase
	end

	// Byte-lane merge helper for full-word registers
	function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = nw[8*b +: 8];
		return res;
	endfunction

	assign wrMerged = mergeLanes(dataOut_reg, pwdata, pstrb);

	// Access tracking: pready high in access phase, one cycle
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			accessDone_reg <= 1'b0;
		else
			accessDone_reg <= psel && penable && !accessDone_reg;
	end

	// Zero-wait answer: ready in the access cycle after every setup
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			pready <= 1'b0;
		else
			pready <= setupPhase;
	end

	// Error flag for addresses outside the map, alongside ready
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			pslverr <= 1'b0;
		else
			pslverr <= setupPhase && !addrValid;
	end

	// Data output value, only masked lines change
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			dataOut_reg <= static_line_pkg::RstDataOut;
		else if (wrStrobe && addrValid && paddr == static_line_pkg::OffDataOut)
			dataOut_reg <= (wrMerged & dataMask_reg) | (dataOut_reg & ~dataMask_reg);
	end

	// Per-line output enable; a cleared bit leaves the line an input
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			outEnable_reg <= static_line_pkg::RstOutEnable;
		else if (wrStrobe && paddr == static_line_pkg::OffOutEnable)
			outEnable_reg <= mergeLanes(outEnable_reg, pwdata, pstrb);
	end

	// Per-line driver type: open drain or driven both ways
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			openDrain_reg <= static_line_pkg::RstOpenDrain;
		else if (wrStrobe && paddr == static_line_pkg::OffOpenDrain)
			openDrain_reg <= mergeLanes(openDrain_reg, pwdata, pstrb);
	end

	// Line mask for masked data writes
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			dataMask_reg <= static_line_pkg::RstDataMask;
		else if (wrStrobe && paddr == static_line_pkg::OffDataMask)
			dataMask_reg <= mergeLanes(dataMask_reg, pwdata, pstrb);
	end

	// Group modes reserve control lines
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			groupMode_reg <= static_line_pkg::RstGroupMode;
		else if (wrStrobe && paddr == static_line_pkg::OffGroupMode && pstrb[0])
			groupMode_reg <= pwdata[static_line_pkg::GroupModeWidth-1:0];
	end

	// Aux line mask selects lines for line-by-line access
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			auxLineMask_reg <= static_line_pkg::RstAuxLineMask;
		else if (wrStrobe && paddr == static_line_pkg::OffAuxLineMask && pstrb[0])
			auxLineMask_reg <= pwdata[AuxWidth-1:0];
	end

	// Whole port when both groups free; else only free, masked lines
	always_comb
	begin
		auxWriteSel = auxPortFree ? {AuxWidth{1'b1}} : (auxLineMask_reg & auxFree);
		auxWriteSel = auxWriteSel & auxFree;
		auxReadSel = auxPortFree ? {AuxWidth{1'b1}} : (auxLineMask_reg & auxFree);
		auxOutNext = (pwdata[AuxWidth-1:0] & auxWriteSel) | (auxOut_reg & ~auxWriteSel);
	end

	// Aux write updates only the four output lines
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			auxOut_reg <= static_line_pkg::RstAuxOut;
		else if (wrStrobe && paddr == static_line_pkg::OffAuxPort && pstrb[0])
			auxOut_reg <= auxOutNext;
	end

	// Pin drive: driven output both levels, open drain low only
	always_comb
	begin
		for (int i = 0; i < DataWidth; i++)
		begin
			pinNext[i] = dataOut_reg[i];
			if (!outEnable_reg[i])
				oenNext[i] = 1'b1;
			else if (openDrain_reg[i])
			begin
				pinNext[i] = 1'b0;
				oenNext[i] = dataOut_reg[i];
			end
			else
				oenNext[i] = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			dataLineOut <= '0;
			dataLineOen <= '1;
		end
		else
		begin
			dataLineOut <= pinNext;
			dataLineOen <= oenNext;
		end
	end

	// Control outputs follow the aux output register
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			peripheralClockLine <= static_line_pkg::RstControlOut;
			replyLine <= static_line_pkg::RstControlOut;
		end
		else
		begin
			peripheralClockLine <= auxOut_reg[1:0];
			replyLine <= auxOut_reg[3:2];
		end
	end

	// Control drivers released while their group is busy
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			controlLineOen <= static_line_pkg::RstControlOen;
		else
			controlLineOen <= {group2Busy, group1Busy};
	end

	// Pull levels tracked for status only; pad applies them to undriven lines
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			pullLevel_reg <= 2'h0;
		else
			pullLevel_reg <= pullSync;
	end

	// Read mux
	always_comb
	begin
		prdata_next = 32'h0000_0000;
		unique case (paddr)
			static_line_pkg::OffDataOut:
				prdata_next = dataOut_reg;
			static_line_pkg::OffDataIn:
				prdata_next = dataSync & dataMask_reg;
			static_line_pkg::OffOutEnable:
				prdata_next = outEnable_reg;
			static_line_pkg::OffOpenDrain:
				prdata_next = openDrain_reg;
			static_line_pkg::OffAuxPort:
				prdata_next[AuxWidth-1:0] = auxSync & auxReadSel;
			static_line_pkg::OffAuxLineMask:
				prdata_next[AuxWidth-1:0] = auxLineMask_reg;
			static_line_pkg::OffGroupMode:
				prdata_next[static_line_pkg::GroupModeWidth-1:0] = groupMode_reg;
			static_line_pkg::OffStatus:
			begin
				prdata_next[static_line_pkg::StatGroup1Busy] = group1Busy;
				prdata_next[static_line_pkg::StatGroup2Busy] = group2Busy;
				prdata_next[static_line_pkg::StatAuxPortFree] = auxPortFree;
				prdata_next[static_line_pkg::StatDataPull] = pullLevel_reg[0];
				prdata_next[static_line_pkg::StatControlPull] = pullLevel_reg[1];
			end
			static_line_pkg::OffDataMask:
				prdata_next = dataMask_reg;
			default:
				prdata_next = 32'h0000_0000;
		endcase
	end

	// Read data latched at setup, stands through access phase
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (setupPhase && !pwrite)
			prdata <= prdata_next;
	end
endmodule

// file: pkg/static_line_pkg.sv
// Package for the static digital line port: register map, field layout, reset values.
// Assumes a 32-bit APB slave with word-aligned registers.
package static_line_pkg;
	localparam int DataWidth = 32;
	localparam int AuxWidth = 4;
	localparam int AddrWidth = 8;

	// Byte offsets of the registers
	localparam logic [7:0] OffDataOut = 8'h00;
	localparam logic [7:0] OffDataIn = 8'h04;
	localparam logic [7:0] OffOutEnable = 8'h08;
	localparam logic [7:0] OffOpenDrain = 8'h0c;
	localparam logic [7:0] OffAuxPort = 8'h10;
	localparam logic [7:0] OffAuxLineMask = 8'h14;
	localparam logic [7:0] OffGroupMode = 8'h18;
	localparam logic [7:0] OffStatus = 8'h1c;
	localparam logic [7:0] OffDataMask = 8'h20;

	// Group mode field: two bits per group, group 1 in bits 1:0, group 2 in bits 3:2
	localparam int GroupModeWidth = 4;
	localparam int Group1Lsb = 0;
	localparam int Group2Lsb = 2;
	localparam logic [1:0] ModeIdle = 2'h0;
	localparam logic [1:0] ModeHandshake = 2'h1;
	localparam logic [1:0] ModePattern = 2'h2;

	// Status register bit positions
	localparam int StatGroup1Busy = 0;
	localparam int StatGroup2Busy = 1;
	localparam int StatAuxPortFree = 2;
	localparam int StatDataPull = 3;
	localparam int StatControlPull = 4;

	// Reset values
	localparam logic [31:0] RstDataOut = 32'h0000_0000;
	localparam logic [31:0] RstOutEnable = 32'h0000_0000;
	localparam logic [31:0] RstOpenDrain = 32'h0000_0000;
	localparam logic [31:0] RstDataMask = 32'hffff_ffff;
	localparam logic [3:0] RstAuxOut = 4'h0;
	localparam logic [3:0] RstAuxLineMask = 4'hf;
	localparam logic [3:0] RstGroupMode = 4'h0;
	localparam logic [1:0] RstControlOut = 2'h0;
	localparam logic [1:0] RstControlOen = 2'h3;
endpackage

// file: core/pin_sync.sv
// Three-stage synchroniser bank for pin inputs with agreement filter.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
module pin_sync #(
	parameter int Width = 32
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [Width-1:0] pinIn,
	output logic [Width-1:0] pinOut
);
	logic [Width-1:0] stage1_reg;
	logic [Width-1:0] stage2_reg;
	logic [Width-1:0] stage3_reg;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end
		else
		begin
			stage1_reg <= pinIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A bit changes once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < Width; i++)
		begin : g_bit
			always_ff @(posedge clock)
			begin
				if (sys_rst)
					pinOut[i] <= 1'b0;
				else if (stage2_reg[i] == stage3_reg[i])
					pinOut[i] <= stage3_reg[i];
			end
		end
	endgenerate
endmodule

// file: test/static_line_port_props.sv
// Checker on the port's bus and pins.
// Assumes binding into static_line_port.
`timescale 1ns/10ps
module static_line_port_props #(
	parameter int DataWidth = 32
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [DataWidth-1:0] dataLineOut,
	input wire logic [DataWidth-1:0] dataLineOen,
	input wire logic [1:0] peripheralClockLine,
	input wire logic [1:0] replyLine,
	input wire logic [1:0] controlLineOen
);
	logic wr;
	// Completed write
	assign wr = psel && penable && pwrite && pready;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_answer; psel && !penable |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_errmap;
		psel && !penable |=> pslverr == ($past(paddr) > 8'h20 || $past(paddr[1:0]) != 2'h0);
	endproperty
	property p_errzero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	property p_rst; $fell(sys_rst) |-> &dataLineOen && dataLineOut == '0 && &controlLineOen
		##1 controlLineOen == 2'h0; endproperty
	property p_outhold; $changed(dataLineOut) |-> $past(wr) || $past(wr, 2); endproperty
	property p_oenhold; $changed(dataLineOen) |-> $past(wr) || $past(wr, 2); endproperty
	property p_auxhold;
		$changed({replyLine, peripheralClockLine}) |-> $past(wr) || $past(wr, 2);
	endproperty
	a_answer: assert property (p_answer) else $error("no ready");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_errmap: assert property (p_errmap) else $error("bad error flag");
	a_errzero: assert property (p_errzero) else $error("error read not zero");
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_outhold: assert property (p_outhold) else $error("out moved");
	a_oenhold: assert property (p_oenhold) else $error("enable moved");
	a_auxhold: assert property (p_auxhold) else $error("aux moved");
	c_auxw: cover property (wr && paddr == 8'h10);
	c_err: cover property (pready && pslverr);
	c_rdin: cover property (pready && !pwrite && paddr == 8'h04);
endmodule
bind static_line_port static_line_port_props #(.DataWidth(DataWidth)) u_props (.clock,
	.sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .dataLineOut,
	.dataLineOen, .peripheralClockLine, .replyLine, .controlLineOen);

// file: test/line_peripheral.sv
// Peripheral model: resolves the data pins.
// Assumes active-low device enables.
`timescale 1ns/10ps
module line_peripheral (
	input wire logic [31:0] devOut,
	input wire logic [31:0] devOen,
	input wire logic pull,
	input wire logic [31:0] periDrive,
	input wire logic [31:0] periVal,
	output logic [31:0] pin
);
	// Device driver, else peripheral, else pull
	assign pin = (~devOen & devOut) | (devOen & periDrive & periVal)
		| (devOen & ~periDrive & {32{pull}});
endmodule

// file: test/tb_top.sv
// Self-checking bench for the static line port.
// Assumes the bound checker and the peripheral model.
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic pull = 1'h0;
	logic control_pull_select = 1'h0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] periDrive = 32'h0;
	logic [31:0] periVal = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [1:0] stopTriggerLine = 2'h0;
	logic [1:0] askLine = 2'h0;
	logic [31:0] prdata, dataLineIn, dataLineOut, dataLineOen, rd, en, od, outReg, mask, wv;
	logic [3:0] auxOut, eff, d, lm;
	logic [1:0] peripheralClockLine, replyLine, controlLineOen;
	logic pready, pslverr, err, f1, f2;
	logic [7:0] ra [7] = '{8'h00, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20};
	logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'hf, 32'h0, 32'h4, 32'hffffffff};
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	static_line_port DUT (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .dataLineIn, .dataLineOut, .dataLineOen,
		.dataPullSelect(pull), .controlPullSelect(control_pull_select), .stopTriggerLine, .askLine,
		.peripheralClockLine, .replyLine, .controlLineOen);
	line_peripheral peri (.devOut(dataLineOut), .devOen(dataLineOen), .pull, .periDrive,
		.periVal, .pin(dataLineIn));
	// Clock
	initial
	begin
		forever #5 clock = ~clock;
	end
	// Hang limit
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("failures %0d checks %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge clock);
	endtask
	// One bus transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clock);
		penable <= 1'h1;
		@(posedge clock);
		while (pready !== 1'h1 && n < 16)
		begin
			@(posedge clock);
			n++;
		end
		if (pready !== 1'h1)
			failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Expected pin levels
	function automatic logic [31:0] pins(logic [31:0] e, o, q, pd, pv, logic p);
		return (e & ~o & q) | (~(e & ~o) & ~(e & o & ~q) & ((pd & pv) | (~pd & {32{p}})));
	endfunction
	// Main sequence
	initial
	begin
		void'($urandom(60));
		repeat (4) @(posedge clock);
		sys_rst <= 1'h0;
		idle(2);
		`CHK(dataLineOen, 32'hffffffff)
		`CHK(controlLineOen, 2'h0)
		foreach (ra[i])
		begin
			apb(1'h0, ra[i], 32'h0);
			`CHK(rd, rv[i])
		end
		apb(1'h0, 8'h24, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		apb(1'h0, 8'h02, 32'h0);
		`CHK({err, rd}, 33'h100000000)
		outReg = 32'h0;
		for (int k = 0; k < 12; k++)
		begin
			en = k ? $urandom : 32'hffffffff;
			od = k ? $urandom : 32'hffffffff;
			mask = $urandom;
			wv = $urandom;
			pull <= 1'($urandom);
			control_pull_select <= 1'($urandom);
			periDrive <= $urandom & ~(en & ~od);
			periVal <= $urandom & ~(en & od);
			apb(1'h1, 8'h20, mask);
			apb(1'h1, 8'h0c, od);
			apb(1'h1, 8'h08, en);
			apb(1'h1, 8'h00, wv);
			outReg = (outReg & ~mask) | (wv & mask);
			idle(8);
			`CHK(dataLineOen, ~(en & ~(od & outReg)))
			`CHK(dataLineOut & ~dataLineOen, outReg & en & ~od)
			apb(1'h0, 8'h04, 32'h0);
			`CHK(rd, pins(en, od, outReg, periDrive, periVal, pull) & mask)
			apb(1'h0, 8'h1c, 32'h0);
			`CHK(rd[4:3], {control_pull_select, pull})
		end
		auxOut = 4'h0;
		for (int g = 0; g < 16; g++)
		begin
			d = 4'($urandom);
			lm = 4'($urandom);
			stopTriggerLine <= 2'($urandom);
			askLine <= 2'($urandom);
			apb(1'h1, 8'h18, 32'(g));
			apb(1'h1, 8'h14, 32'(lm));
			apb(1'h1, 8'h10, 32'(d));
			f1 = g[1:0] == 2'h0;
			f2 = g[3:2] == 2'h0;
			eff = (f1 && f2) ? 4'hf : lm & {f2, f1, f2, f1};
			auxOut = (auxOut & ~eff) | (d & eff);
			idle(8);
			`CHK({replyLine, peripheralClockLine}, auxOut)
			`CHK(controlLineOen, {!f2, !f1})
			apb(1'h0, 8'h10, 32'h0);
			`CHK(rd, {28'h0, askLine, stopTriggerLine} & eff)
			apb(1'h0, 8'h1c, 32'h0);
			`CHK(rd[2:0], {f1 && f2, !f2, !f1})
		end
		@(posedge clock);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'h0;
		idle(2);
		`CHK(dataLineOen, 32'hffffffff)
		`CHK(controlLineOen, 2'h0)
		apb(1'h0, 8'h18, 32'h0);
		`CHK(rd, 32'h0)
		print_verdict();
	end
endmodule
